// [core/nlch_node_list_handler.sv]
// node list command handler: projected, fault and enabled node lists,
// extended ID1 write to node 0, permanent parameters restored at power-on
// assumes synchronous inputs, a retained store outside, segment scan outside
// assumes one host at a time and a node side that acks every transfer
// Contract
// - set-list 0x29 with 9-byte payload writes the expected bitmap to retained store
// - list bit 1 means node expected at that address, 0 means not
// - read-fault 0x3E, no payload, returns 8-byte peripheral fault bitmap
// - fault bitmap is refreshed periodically while running
// - fault bit is 1 only for an enabled node reporting a fault
// - ID1 write 0x3F with 1-byte payload goes to the node at address 0
// - only the low 4 bits of the ID1 value pass to the node, unchecked; the upper 4 bits are dropped
// - parameter store 0x43 with 2-byte payload saves 4 bits for addressed node
// - after every power-on each stored parameter is sent to its node
// - read-projected 0x44, no payload, returns stored 8-byte bitmap
// - read-enabled 0x45, no payload, returns 8-byte enabled node bitmap
// - bitmap positions that cannot hold a node carry no meaning, read zero
// - protected mode enables only projected nodes with matching configuration
`timescale 1ns/10ps
`include "nlch_map.svh"
module nlch_node_list_handler import nlch_pkg::*; #(
    parameter int unsigned FAULT_REFRESH_CYC = `NLCH_FAULT_REFRESH_CYC
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // request byte stream
    input wire logic req_valid_in,
    input wire nlch_byte_s req_in,
    output logic req_ready_out,
    // response byte stream
    output logic resp_valid_out,
    output nlch_byte_s resp_out,
    input wire logic resp_ready_in,
    // segment scan state
    input wire logic [63:0] node_detected_in,
    input wire logic [63:0] node_fault_in,
    input wire logic [63:0] node_cfg_ok_in,
    input wire logic config_mode_in,
    // transfers towards nodes
    output logic node_req_valid_out,
    output nlch_node_req_s node_req_out,
    input wire logic node_ack_in,
    // retained store
    input wire logic [63:0] nv_proj_in,
    output logic nv_proj_wr_out,
    output logic [63:0] nv_proj_out,
    output logic [5:0] nv_parm_rd_idx_out,
    input wire logic [3:0] nv_parm_rd_in,
    output logic nv_parm_wr_out,
    output nlch_parm_wr_s nv_parm_out,
    // status
    output logic init_done_out,
    output logic [63:0] projected_node_list_out,
    output logic [63:0] enabled_node_list_out,
    output logic [63:0] peripheral_fault_list_out
);
    logic rst_meta_q;
    logic rst_sync_q;
    nlch_state_e state_q;
    logic [3:0] idx_q;
    logic [7:0] rq_q [0:10];
    logic [63:0] proj_q;
    logic [63:0] enab_q;
    logic [63:0] fault_q;
    logic [15:0] tick_cnt_q;
    logic [5:0] pidx_q;
    logic node_valid_q;
    nlch_node_req_s node_req_q;
    logic nv_proj_wr_q;
    logic nv_parm_wr_q;
    nlch_parm_wr_s nv_parm_q;
    logic [63:0] resp_map_q;
    logic [7:0] hdr_q;
    logic [3:0] resp_len_q;
    logic [3:0] ridx_q;
    logic resp_valid_q;
    nlch_byte_s resp_q;

    // reset release through two flops
    // asserts at once, releases on a clock edge to avoid recovery hazards
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // refresh tick divider
    logic tick;
    // one tick per refresh period; the enabled and fault lists move only on it
    assign tick = (tick_cnt_q == 16'(FAULT_REFRESH_CYC - 1));
    always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        end
    end

    // enabled and fault lists from the scan
    // configuration mode enables every detected node,
    // protected mode only projected nodes whose configuration matches
    logic [63:0] enab_d;
    logic [63:0] fault_d;
    assign enab_d = (config_mode_in ? node_detected_in
        : (proj_q & node_detected_in & node_cfg_ok_in)) & `NLCH_MAP_VALID;
    // a fault only counts on an enabled node
    assign fault_d = node_fault_in & enab_d;
    always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            enab_q <= `NLCH_MAP_RESET;
            fault_q <= `NLCH_MAP_RESET;
        end else if (tick) begin
            enab_q <= enab_d;
            fault_q <= fault_d;
        end
    end

    // request decode
    logic [7:0] cmd;
    logic is_set_proj;
    logic is_list;
    logic is_id1;
    logic is_parm;
    logic [3:0] exp_len;
    logic [6:0] err;
    logic [63:0] req_map;
    logic [63:0] sel_map;
    assign cmd = rq_q[0];
    assign is_set_proj = (cmd == `NLCH_CMD_SET_PROJ);
    assign is_id1 = (cmd == `NLCH_CMD_WR_ID1);
    assign is_parm = (cmd == `NLCH_CMD_SET_PARM);
    assign is_list = (cmd == `NLCH_CMD_GET_FAULT) || (cmd == `NLCH_CMD_GET_PROJ)
        || (cmd == `NLCH_CMD_GET_ENAB);
    assign exp_len = is_set_proj ? `NLCH_LEN_SET_PROJ : is_id1 ? `NLCH_LEN_WR_ID1
        : is_parm ? `NLCH_LEN_SET_PARM : `NLCH_LEN_LIST;
    // unknown code wins over a length error; either blocks the action
    assign err = !(is_set_proj || is_id1 || is_parm || is_list) ? `NLCH_ERR_UNKNOWN
        : (idx_q != exp_len) ? `NLCH_ERR_LENGTH : `NLCH_ERR_NONE;
    // bytes 3..10 carry addresses 0A..31B, low address in low bit
    assign req_map = {rq_q[10], rq_q[9], rq_q[8], rq_q[7],
        rq_q[6], rq_q[5], rq_q[4], rq_q[3]} & `NLCH_MAP_VALID;
    assign sel_map = (cmd == `NLCH_CMD_GET_FAULT) ? fault_q
        : (cmd == `NLCH_CMD_GET_ENAB) ? enab_q : proj_q;

    // next response byte
    // byte 0 is loaded in exec, or on the node ack for ID1; the rest follow one per accepted byte
    logic [3:0] rb_idx;
    logic [2:0] rb_map;
    logic [7:0] rb_byte;
    logic rb_last;
    logic exec_ok;
    assign rb_idx = ridx_q + 4'h1;
    assign rb_map = 3'(rb_idx - 4'h2);
    assign rb_byte = (rb_idx == 4'h1) ? hdr_q : resp_map_q[{rb_map, 3'b000} +: 8];
    assign rb_last = (rb_idx == resp_len_q - 4'h1);
    assign exec_ok = (state_q == ST_EXEC) && (err == `NLCH_ERR_NONE);

    // request byte capture
    // bytes past the last slot are counted but not kept
    always_ff @(posedge clk_sys_in) begin
        if (state_q == ST_IDLE && req_valid_in && idx_q <= `NLCH_MAX_IDX) begin
            rq_q[idx_q] <= req_in.data;
        end
    end

    // power-on parameter walk helpers
    logic pidx_valid;
    logic pidx_done;
    logic [63:0] map_valid;
    assign map_valid = `NLCH_MAP_VALID;
    // positions 0A and 0B hold no node and are skipped
    assign pidx_valid = map_valid[pidx_q];
    assign pidx_done = (pidx_q == `NLCH_LAST_NODE);

    // main sequencer
    always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= ST_INIT_LOAD;
            idx_q <= 4'h0;
            pidx_q <= 6'h00;
            proj_q <= `NLCH_MAP_RESET;
            node_valid_q <= 1'b0;
            node_req_q <= '0;
            hdr_q <= 8'h00;
            resp_len_q <= `NLCH_LEN_RESP_SHORT;
            resp_map_q <= `NLCH_MAP_RESET;
            ridx_q <= 4'h0;
            resp_valid_q <= 1'b0;
            resp_q <= '0;
        end else begin
            case (state_q)
                // take the retained list once after reset
                ST_INIT_LOAD: begin
                    proj_q <= nv_proj_in & `NLCH_MAP_VALID;
                    pidx_q <= 6'h00;
                    state_q <= ST_INIT_SEND;
                end
                // one parameter per node, each waits for its ack
                ST_INIT_SEND: begin
                    if (node_valid_q) begin
                        if (node_ack_in) begin
                            node_valid_q <= 1'b0;
                            pidx_q <= pidx_q + 6'h01;
                            state_q <= pidx_done ? ST_IDLE : ST_INIT_SEND;
                        end
                    end else if (pidx_valid) begin
                        node_valid_q <= 1'b1;
                        node_req_q <= '{kind: NODE_PARAM, addr: pidx_q, data: nv_parm_rd_in};
                    end else begin
                        pidx_q <= pidx_q + 6'h01;
                        state_q <= pidx_done ? ST_IDLE : ST_INIT_SEND;
                    end
                end
                // collect request bytes until the last flag
                ST_IDLE: begin
                    if (req_valid_in) begin
                        idx_q <= (idx_q == 4'hF) ? idx_q : idx_q + 4'h1;
                        state_q <= req_in.last ? ST_EXEC : ST_IDLE;
                    end
                end
                // act on the request and load the response header
                ST_EXEC: begin
                    hdr_q <= {rq_q[1][`NLCH_TOGGLE_BIT], err};
                    resp_map_q <= sel_map;
                    resp_len_q <= (is_list && err == `NLCH_ERR_NONE) ?
                        `NLCH_LEN_RESP_LIST : `NLCH_LEN_RESP_SHORT;
                    if (exec_ok && is_set_proj) begin
                        proj_q <= req_map;
                    end
                    if (exec_ok && is_id1) begin
                        node_valid_q <= 1'b1;
                        node_req_q <= '{kind: NODE_ID1, addr: `NLCH_ADDR_ZERO,
                            data: rq_q[2][3:0]};
                        state_q <= ST_WAIT_NODE;
                    end else begin
                        resp_valid_q <= 1'b1;
                        resp_q <= '{last: 1'b0, data: cmd};
                        ridx_q <= 4'h0;
                        state_q <= ST_RESP;
                    end
                end
                // no timeout: a silent node stalls the host
                ST_WAIT_NODE: begin
                    if (node_ack_in) begin
                        node_valid_q <= 1'b0;
                        resp_valid_q <= 1'b1;
                        resp_q <= '{last: 1'b0, data: cmd};
                        ridx_q <= 4'h0;
                        state_q <= ST_RESP;
                    end
                end
                // hand out response bytes as the host takes them
                ST_RESP: begin
                    if (resp_ready_in) begin
                        if (resp_q.last) begin
                            resp_valid_q <= 1'b0;
                            idx_q <= 4'h0;
                            state_q <= ST_IDLE;
                        end else begin
                            resp_q <= '{last: rb_last, data: rb_byte};
                            ridx_q <= rb_idx;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // retained store write strobes
    // exec lasts one cycle, so each strobe is a single pulse
    always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            nv_proj_wr_q <= 1'b0;
            nv_parm_wr_q <= 1'b0;
            nv_parm_q <= '0;
        end else begin
            nv_proj_wr_q <= exec_ok && is_set_proj;
            nv_parm_wr_q <= exec_ok && is_parm;
            if (exec_ok && is_parm) begin
                nv_parm_q <= '{idx: rq_q[2][5:0], data: rq_q[3][3:0]};
            end
        end
    end

    // outputs
    // ready and init done are decoded from the state, everything else comes from flops
    assign req_ready_out = (state_q == ST_IDLE);
    assign resp_valid_out = resp_valid_q;
    assign resp_out = resp_q;
    assign node_req_valid_out = node_valid_q;
    assign node_req_out = node_req_q;
    assign nv_proj_wr_out = nv_proj_wr_q;
    assign nv_proj_out = proj_q;
    assign nv_parm_rd_idx_out = pidx_q;
    assign nv_parm_wr_out = nv_parm_wr_q;
    assign nv_parm_out = nv_parm_q;
    assign init_done_out = (state_q != ST_INIT_LOAD) && (state_q != ST_INIT_SEND);
    assign projected_node_list_out = proj_q;
    assign enabled_node_list_out = enab_q;
    assign peripheral_fault_list_out = fault_q;
endmodule

// [common/nlch_map.svh]
// constants of the node list command handler: codes, lengths, masks, timing
// assumes a 10 MHz system clock; included by bare name
`ifndef NLCH_MAP_SVH
`define NLCH_MAP_SVH
// command codes
`define NLCH_CMD_SET_PROJ 8'h29
`define NLCH_CMD_GET_FAULT 8'h3E
`define NLCH_CMD_WR_ID1 8'h3F
`define NLCH_CMD_SET_PARM 8'h43
`define NLCH_CMD_GET_PROJ 8'h44
`define NLCH_CMD_GET_ENAB 8'h45
// request lengths in bytes, code and header byte included
`define NLCH_LEN_SET_PROJ 4'hB
`define NLCH_LEN_LIST 4'h2
`define NLCH_LEN_WR_ID1 4'h3
`define NLCH_LEN_SET_PARM 4'h4
// response lengths in bytes
`define NLCH_LEN_RESP_SHORT 4'h2
`define NLCH_LEN_RESP_LIST 4'hA
// last request byte index kept, first bitmap byte of set list
`define NLCH_MAX_IDX 4'hA
`define NLCH_MAP_BYTE 4'h3
// field positions in header byte and address byte
`define NLCH_TOGGLE_BIT 7
`define NLCH_ERR_NONE 7'h00
`define NLCH_ERR_UNKNOWN 7'h01
`define NLCH_ERR_LENGTH 7'h02
// positions 0A and 0B carry no node
`define NLCH_MAP_VALID 64'hFFFF_FFFE_FFFF_FFFE
`define NLCH_MAP_RESET 64'h0000_0000_0000_0000
`define NLCH_ADDR_ZERO 6'h00
`define NLCH_LAST_NODE 6'h3F
// fault list refresh period
`define NLCH_CLK_MHZ 10
`define NLCH_FAULT_REFRESH_US 1000
`define NLCH_FAULT_REFRESH_CYC (`NLCH_FAULT_REFRESH_US * `NLCH_CLK_MHZ)
`endif

// [common/nlch_pkg.sv]
// types of the node list command handler
// assumes nlch_map.svh for the numeric constants
package nlch_pkg;
    typedef enum logic [2:0] {
        ST_INIT_LOAD = 3'b000,
        ST_INIT_SEND = 3'b001,
        ST_IDLE = 3'b010,
        ST_EXEC = 3'b011,
        ST_WAIT_NODE = 3'b100,
        ST_RESP = 3'b101
    } nlch_state_e;
    typedef enum logic {
        NODE_PARAM = 1'b0,
        NODE_ID1 = 1'b1
    } nlch_node_kind_e;
    // one byte of a request or response stream
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } nlch_byte_s;
    // one transfer towards a node on the segment
    typedef struct packed {
        nlch_node_kind_e kind;
        logic [5:0] addr;
        logic [3:0] data;
    } nlch_node_req_s;
    // write of one permanent parameter into the retained store
    typedef struct packed {
        logic [5:0] idx;
        logic [3:0] data;
    } nlch_parm_wr_s;
endpackage

// [tb/nlch_checker.sv]
// port assertions of the node list handler
// bound to the handler from tb_top, sees its ports only
`timescale 1ns/10ps
`include "nlch_map.svh"
module nlch_checker import nlch_pkg::*; #(
    parameter int unsigned FAULT_REFRESH_CYC = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // host and node streams
    input wire logic req_ready_out,
    input wire logic resp_valid_out,
    input wire nlch_byte_s resp_out,
    input wire logic resp_ready_in,
    input wire logic node_req_valid_out,
    input wire nlch_node_req_s node_req_out,
    input wire logic node_ack_in,
    // store and lists
    input wire logic nv_proj_wr_out,
    input wire logic [63:0] nv_proj_out,
    input wire logic nv_parm_wr_out,
    input wire logic init_done_out,
    input wire logic [63:0] projected_node_list_out,
    input wire logic [63:0] enabled_node_list_out,
    input wire logic [63:0] peripheral_fault_list_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // cycles since either list last moved
    logic [15:0] gap_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_q <= 16'h0000;
        end else if ($changed(enabled_node_list_out) || $changed(peripheral_fault_list_out)) begin
            gap_q <= 16'h0000;
        end else if (gap_q != 16'hFFFF) begin
            gap_q <= gap_q + 16'h0001;
        end
    end
    refresh_gap_a: assert property ($changed(enabled_node_list_out)
        |-> gap_q >= 16'(FAULT_REFRESH_CYC - 1)) else $error("list moved between ticks");
    // response and request streams
    resp_hold_a: assert property (resp_valid_out && !resp_ready_in
        |=> resp_valid_out && $stable(resp_out)) else $error("response byte changed");
    one_req_a: assert property (resp_valid_out |-> !req_ready_out)
        else $error("request taken while answering");
    // store pulses
    proj_store_a: assert property (nv_proj_wr_out
        |-> ((nv_proj_out & ~`NLCH_MAP_VALID) == '0) ##1 !nv_proj_wr_out) else $error("list store");
    parm_pulse_a: assert property (nv_parm_wr_out |=> !nv_parm_wr_out)
        else $error("parameter store pulse");
    // list relations
    fault_sub_a: assert property ((peripheral_fault_list_out & ~enabled_node_list_out) == '0)
        else $error("fault on a node not enabled");
    void_pos_a: assert property (((enabled_node_list_out | peripheral_fault_list_out)
        & ~`NLCH_MAP_VALID) == '0) else $error("void position set");
    // node transfers
    id1_addr_a: assert property (node_req_valid_out && node_req_out.kind == NODE_ID1
        |-> node_req_out.addr == 6'h00 && init_done_out) else $error("ID1 address");
    node_hold_a: assert property (node_req_valid_out && !node_ack_in
        |=> node_req_valid_out && $stable(node_req_out)) else $error("node transfer changed");
    node_drop_a: assert property (node_req_valid_out && node_ack_in |=> !node_req_valid_out)
        else $error("node transfer kept after ack");
    walk_a: assert property (node_req_valid_out && !init_done_out |->
        node_req_out.kind == NODE_PARAM && node_req_out.addr[4:0] != 5'h00) else $error("walk");
    // main scenarios
    cover property (nv_proj_wr_out);
    cover property (nv_parm_wr_out);
    cover property (node_req_valid_out && node_req_out.kind == NODE_ID1);
endmodule

// [tb/nlch_seg_model.sv]
// segment nodes and retained parameter store facing the handler
// acks each node transfer delay_in + 1 cycles after it is raised, store read is combinational
`timescale 1ns/10ps
module nlch_seg_model import nlch_pkg::*; (
    // clock and answer delay
    input wire logic clk_sys_in,
    input wire logic [3:0] delay_in,
    // node link and store
    input wire logic node_req_valid_in,
    input wire nlch_node_req_s node_req_in,
    output logic node_ack_out,
    input wire logic [5:0] nv_parm_rd_idx_in,
    output logic [3:0] nv_parm_rd_out,
    // log of transfers
    output int n_param_out,
    output int bad_param_out,
    output nlch_node_req_s last_id1_out
);
    logic [3:0] wait_q = 4'h0;
    // stored value from the low 4 address bits, repeating every 16 nodes
    assign nv_parm_rd_out = nv_parm_rd_idx_in[3:0] ^ 4'h5;
    initial begin
        node_ack_out = 1'b0;
        n_param_out = 0;
        bad_param_out = 0;
        last_id1_out = '0;
    end
    // one-cycle ack after the delay, logging the transfer
    always @(posedge clk_sys_in) begin
        node_ack_out <= 1'b0;
        if (node_req_valid_in && !node_ack_out) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == delay_in) begin
                node_ack_out <= 1'b1;
                wait_q <= 4'h0;
                if (node_req_in.kind == NODE_ID1) begin
                    last_id1_out <= node_req_in;
                end else begin
                    n_param_out <= n_param_out + 1;
                    if (node_req_in.data !== (node_req_in.addr[3:0] ^ 4'h5)) begin
                        bad_param_out <= bad_param_out + 1;
                    end
                end
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// bench of the node list handler: command sequences with expected answers
// assumes the segment model and the checker beside it
`timescale 1ns/10ps
`include "nlch_map.svh"
module tb_top import nlch_pkg::*; ();
    localparam logic [63:0] V = `NLCH_MAP_VALID;
    localparam logic [63:0] L0 = 64'h0F0F_0F0F_F0F0_F0F1;
    localparam logic [63:0] P = 64'hA5A5_0F0E_1234_5678;
    localparam logic [63:0] D = 64'hFFFF_0000_FFFF_00FF;
    localparam logic [63:0] C = 64'hFFFF_FFFF_0000_FFFF;
    localparam logic [63:0] F = 64'h5555_5555_5555_5555;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    logic resp_ready_in = 1'b0;
    logic cmode = 1'b1;
    logic tog = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [63:0] flt = F;
    nlch_byte_s req_in = '0;
    logic req_ready_out, resp_valid_out, nreq_v, ack, proj_wr, parm_wr, init_done_out;
    nlch_byte_s resp_out;
    nlch_node_req_s nreq, last_id1;
    nlch_parm_wr_s parm, parm_seen = '0;
    logic [63:0] proj_st, proj_seen = '0;
    logic [63:0] proj_l, enab_l, fault_l;
    logic [5:0] parm_idx;
    logic [3:0] parm_rd;
    logic [7:0] rq [11];
    logic [7:0] rs [16];
    int failures = 0, n_tests = 0, n_param, bad_param, k, cyc = 0;

    nlch_node_list_handler #(.FAULT_REFRESH_CYC(8)) nlch_node_list_handler_i (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
        .resp_out(resp_out), .resp_ready_in(resp_ready_in), .node_detected_in(D),
        .node_fault_in(flt), .node_cfg_ok_in(C), .config_mode_in(cmode),
        .node_req_valid_out(nreq_v), .node_req_out(nreq), .node_ack_in(ack), .nv_proj_in(L0),
        .nv_proj_wr_out(proj_wr), .nv_proj_out(proj_st), .nv_parm_rd_idx_out(parm_idx),
        .nv_parm_rd_in(parm_rd), .nv_parm_wr_out(parm_wr), .nv_parm_out(parm),
        .init_done_out(init_done_out), .projected_node_list_out(proj_l),
        .enabled_node_list_out(enab_l), .peripheral_fault_list_out(fault_l));
    nlch_seg_model nlch_seg_model_i (
        .clk_sys_in(clk_sys_in), .delay_in(dly), .node_req_valid_in(nreq_v),
        .node_req_in(nreq), .node_ack_out(ack), .nv_parm_rd_idx_in(parm_idx),
        .nv_parm_rd_out(parm_rd),
        .n_param_out(n_param), .bad_param_out(bad_param), .last_id1_out(last_id1));

    always #50 clk_sys_in = ~clk_sys_in;
    // store capture and hang guard
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (proj_wr === 1'b1) begin
            proj_seen <= proj_st;
        end
        if (parm_wr === 1'b1) begin
            parm_seen <= parm;
        end
        if (cyc == 6000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // send n request bytes, stall once, then take the whole response
    task automatic cmd(input int n, input int nr, input logic [6:0] err);
        logic lst;
        lst = 1'b0;
        k = 0;
        rq[1] = {tog, 7'h00};
        for (int i = 0; i < n; i++) begin
            req_valid_in <= 1'b1;
            req_in <= '{last: (i == n - 1), data: rq[i]};
            do @(posedge clk_sys_in); while (req_ready_out !== 1'b1);
        end
        req_valid_in <= 1'b0;
        do @(posedge clk_sys_in); while (resp_valid_out !== 1'b1);
        resp_ready_in <= 1'b1;
        while (lst !== 1'b1) begin
            @(posedge clk_sys_in);
            if (resp_valid_out === 1'b1 && k < 16) begin
                rs[k] = resp_out.data;
                lst = resp_out.last;
                k++;
            end
        end
        resp_ready_in <= 1'b0;
        chk(k, nr);
        chk(rs[0], rq[0]);
        chk(rs[1], {tog, err});
        tog = ~tog;
    endtask
    task automatic lget(input logic [7:0] code, input logic [63:0] exp);
        logic [63:0] got;
        rq[0] = code;
        cmd(2, 10, `NLCH_ERR_NONE);
        for (int i = 0; i < 8; i++) begin
            got[8*i+:8] = rs[2+i];
        end
        chk(got, exp);
    endtask
    // main command sequence
    initial begin
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 3000 && init_done_out !== 1'b1; i++) @(posedge clk_sys_in);
        chk(n_param, 62);
        chk(bad_param, 0);
        lget(`NLCH_CMD_GET_PROJ, L0 & V);
        chk(proj_l, L0 & V);
        for (int i = 0; i < 8; i++) begin
            rq[3+i] = P[8*i+:8];
        end
        rq[0] = `NLCH_CMD_SET_PROJ;
        rq[2] = 8'h00;
        cmd(11, 2, `NLCH_ERR_NONE);
        chk(proj_seen, P);
        lget(`NLCH_CMD_GET_PROJ, P);
        cmode <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        lget(`NLCH_CMD_GET_ENAB, P & D & C & V);
        chk(enab_l, P & D & C & V);
        lget(`NLCH_CMD_GET_FAULT, F & P & D & C & V);
        flt <= ~F;
        repeat (20) @(posedge clk_sys_in);
        lget(`NLCH_CMD_GET_FAULT, ~F & P & D & C & V);
        chk(fault_l, ~F & P & D & C & V);
        cmode <= 1'b1;
        repeat (20) @(posedge clk_sys_in);
        lget(`NLCH_CMD_GET_ENAB, D & V);
        lget(`NLCH_CMD_GET_FAULT, ~F & D & V);
        dly <= 4'h3;
        rq[0] = `NLCH_CMD_WR_ID1;
        rq[2] = 8'hFB;
        cmd(3, 2, `NLCH_ERR_NONE);
        chk(last_id1, {NODE_ID1, 6'h00, 4'hB});
        rq[0] = `NLCH_CMD_SET_PARM;
        rq[2] = 8'h25;
        rq[3] = 8'h09;
        cmd(4, 2, `NLCH_ERR_NONE);
        chk(parm_seen, {6'h25, 4'h9});
        rq[0] = 8'h30;
        cmd(2, 2, `NLCH_ERR_UNKNOWN);
        rq[0] = `NLCH_CMD_GET_PROJ;
        cmd(3, 2, `NLCH_ERR_LENGTH);
        results();
    end
endmodule
bind nlch_node_list_handler nlch_checker #(.FAULT_REFRESH_CYC(FAULT_REFRESH_CYC)) nlch_checker_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_out(resp_out), .resp_ready_in(resp_ready_in),
    .node_req_valid_out(node_req_valid_out), .node_req_out(node_req_out),
    .node_ack_in(node_ack_in), .nv_proj_wr_out(nv_proj_wr_out), .nv_proj_out(nv_proj_out),
    .nv_parm_wr_out(nv_parm_wr_out), .init_done_out(init_done_out),
    .projected_node_list_out(projected_node_list_out),
    .enabled_node_list_out(enabled_node_list_out),
    .peripheral_fault_list_out(peripheral_fault_list_out));
